// ==== logic/ift_pkg.sv ====
package ift_pkg;

  // -----------------------------------------------------------------
  // Register map (byte addresses on the peripheral bus)
  // -----------------------------------------------------------------
  localparam logic [31:0] RAW_INTERRUPT_STATUS_ADDR = 32'h5000_1534;
  localparam logic [31:0] RECEIVE_THRESHOLD_ADDR = 32'h5000_1538;
  localparam logic [31:0] TRANSMIT_THRESHOLD_ADDR = 32'h5000_153c;
  localparam logic [31:0] CLEAR_ALL_INTERRUPTS_ADDR = 32'h5000_1540;

  // -----------------------------------------------------------------
  // Field layout and reset values
  // -----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int THR_W = 5;
  localparam int LEVEL_W = 6;
  localparam int RX_UNDER_BIT = 0;
  localparam int RX_FULL_BIT = 2;
  localparam int TX_EMPTY_BIT = 4;
  localparam int CLEAR_ALL_BIT = 0;
  localparam int FIFO_DEPTH_DEFAULT = 32;
  localparam logic [THR_W-1:0] THR_RESET = 5'h00;
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;

endpackage // ift_pkg

// ==== logic/ift_thr_reg.sv ====
`timescale 1ns/100ps

module ift_thr_reg #(
  parameter int FIFO_DEPTH = ift_pkg::FIFO_DEPTH_DEFAULT,
  parameter bit AT_OR_ABOVE = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [ift_pkg::THR_W-1:0] wdata_i,
  input wire logic [ift_pkg::LEVEL_W-1:0] level_i,
  input wire logic enable_i,
  output logic [ift_pkg::THR_W-1:0] thr_o,
  output logic flag_o
);

  localparam logic [ift_pkg::THR_W-1:0] THR_MAX = ift_pkg::THR_W'(FIFO_DEPTH - 1);

  logic [ift_pkg::THR_W-1:0] thr_reg;
  logic [ift_pkg::THR_W-1:0] thr_next;
  logic flag_reg;
  logic flag_next;
  logic [ift_pkg::LEVEL_W-1:0] thr_wide;

  // -----------------------------------------------------------------
  // Threshold storage and level compare
  // -----------------------------------------------------------------
  always_comb begin
    thr_next = thr_reg;
    if (wr_en_i) begin
      // Oversized writes saturate at the deepest usable level
      if (wdata_i > THR_MAX) begin
        thr_next = THR_MAX;
      end else begin
        thr_next = wdata_i;
      end
    end
    thr_wide = {1'b0, thr_reg};
    if (AT_OR_ABOVE) begin
      // Field value N means N+1 entries; flushed FIFO never counts as full
      flag_next = enable_i && (level_i >= thr_wide + 6'h01);
    end else begin
      flag_next = enable_i && (level_i <= thr_wide);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thr_reg <= ift_pkg::THR_RESET;
      flag_reg <= 1'b0;
    end else begin
      thr_reg <= thr_next;
      flag_reg <= flag_next;
    end
  end

  assign thr_o = thr_reg;
  assign flag_o = flag_reg;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  property p_thr_clamp;
    @(posedge clk_i) disable iff (rst_i)
    wr_en_i && (wdata_i > THR_MAX) |=> thr_reg == THR_MAX;
  endproperty
  a_thr_clamp: assert property (p_thr_clamp)
    else $error("threshold not saturated at fifo depth");

  property p_thr_store;
    @(posedge clk_i) disable iff (rst_i)
    wr_en_i && (wdata_i <= THR_MAX) |=> thr_reg == $past(wdata_i);
  endproperty
  a_thr_store: assert property (p_thr_store)
    else $error("threshold write not stored");

endmodule // ift_thr_reg

// ==== logic/ift_fifo_thr_irq.sv ====
`timescale 1ns/100ps


module ift_fifo_thr_irq #(
  parameter int FIFO_DEPTH = ift_pkg::FIFO_DEPTH_DEFAULT
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PADDR_I,
  input wire logic [ift_pkg::DATA_W-1:0] PWDATA_I,
  output logic [ift_pkg::DATA_W-1:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic DATA_READ_I,
  input wire logic [ift_pkg::LEVEL_W-1:0] RX_LEVEL_I,
  input wire logic [ift_pkg::LEVEL_W-1:0] TX_LEVEL_I,
  input wire logic ENABLE_I,
  input wire logic INTERNAL_ENABLE_I,
  input wire logic [ift_pkg::DATA_W-1:0] RAW_OTHER_I,
  output logic RX_UNDER_O,
  output logic RX_FULL_O,
  output logic TX_EMPTY_O,
  output logic CLEAR_ALL_O
);

  localparam logic [ift_pkg::THR_W-1:0] THR_MAX = ift_pkg::THR_W'(FIFO_DEPTH - 1);

  logic setup;
  logic access;
  logic hit_raw;
  logic hit_rx;
  logic hit_tx;
  logic hit_clr;
  logic clear_all_rd;
  logic under_event;
  logic [ift_pkg::THR_W-1:0] rx_thr;
  logic [ift_pkg::THR_W-1:0] tx_thr;
  logic rx_full;
  logic tx_empty;
  logic [ift_pkg::DATA_W-1:0] raw_flags;
  logic [ift_pkg::DATA_W-1:0] rdata_reg;
  logic [ift_pkg::DATA_W-1:0] rdata_next;
  logic slverr_reg;
  logic slverr_next;
  logic rx_under_reg;
  logic rx_under_next;
  logic clear_all_reg;
  logic clear_all_next;

  // -----------------------------------------------------------------
  // Bus decode
  // -----------------------------------------------------------------
  assign setup = PSEL_I && !PENABLE_I;
  assign access = PSEL_I && PENABLE_I;
  assign hit_raw = PADDR_I == ift_pkg::RAW_INTERRUPT_STATUS_ADDR;
  assign hit_rx = PADDR_I == ift_pkg::RECEIVE_THRESHOLD_ADDR;
  assign hit_tx = PADDR_I == ift_pkg::TRANSMIT_THRESHOLD_ADDR;
  assign hit_clr = PADDR_I == ift_pkg::CLEAR_ALL_INTERRUPTS_ADDR;
  // Side effect fires once, in the access phase only
  assign clear_all_rd = access && !PWRITE_I && hit_clr;
  assign under_event = DATA_READ_I && (RX_LEVEL_I == 6'h00);

  // -----------------------------------------------------------------
  // Threshold registers
  // -----------------------------------------------------------------
  ift_thr_reg #(
    .FIFO_DEPTH(FIFO_DEPTH),
    .AT_OR_ABOVE(1'b1)
  ) u_rx_thr (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .wr_en_i(access && PWRITE_I && hit_rx),
    .wdata_i(PWDATA_I[ift_pkg::THR_W-1:0]),
    .level_i(RX_LEVEL_I),
    .enable_i(ENABLE_I),
    .thr_o(rx_thr),
    .flag_o(rx_full)
  );

  ift_thr_reg #(
    .FIFO_DEPTH(FIFO_DEPTH),
    .AT_OR_ABOVE(1'b0)
  ) u_tx_thr (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .wr_en_i(access && PWRITE_I && hit_tx),
    .wdata_i(PWDATA_I[ift_pkg::THR_W-1:0]),
    .level_i(TX_LEVEL_I),
    .enable_i(1'b1),
    .thr_o(tx_thr),
    .flag_o(tx_empty)
  );

  // -----------------------------------------------------------------
  // Underflow flag and clear-all pulse
  // -----------------------------------------------------------------
  always_comb begin
    rx_under_next = rx_under_reg;
    // New underflow beats a same-cycle clear so no event is lost
    if (under_event) begin
      rx_under_next = 1'b1;
    end else if (clear_all_rd) begin
      rx_under_next = 1'b0;
    end else if (!INTERNAL_ENABLE_I) begin
      // Internal enable only drops after the state machines idle
      rx_under_next = 1'b0;
    end
    // Abort source block applies its own bit 9 exception on this pulse
    clear_all_next = clear_all_rd;
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      rx_under_reg <= 1'b0;
      clear_all_reg <= 1'b0;
    end else begin
      rx_under_reg <= rx_under_next;
      clear_all_reg <= clear_all_next;
    end
  end

  // -----------------------------------------------------------------
  // Read data
  // -----------------------------------------------------------------
  always_comb begin
    raw_flags = RAW_OTHER_I;
    raw_flags[ift_pkg::RX_UNDER_BIT] = rx_under_reg;
    raw_flags[ift_pkg::RX_FULL_BIT] = rx_full;
    raw_flags[ift_pkg::TX_EMPTY_BIT] = tx_empty;
    rdata_next = rdata_reg;
    slverr_next = 1'b0;
    if (setup) begin
      rdata_next = ift_pkg::REG_RESET;
      if (hit_raw) begin
        rdata_next = raw_flags;
      end else if (hit_rx) begin
        rdata_next[ift_pkg::THR_W-1:0] = rx_thr;
      end else if (hit_tx) begin
        rdata_next[ift_pkg::THR_W-1:0] = tx_thr;
      end else if (!hit_clr) begin
        slverr_next = 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      rdata_reg <= ift_pkg::REG_RESET;
      slverr_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      slverr_reg <= slverr_next;
    end
  end

  assign PRDATA_O = rdata_reg;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = slverr_reg && access;
  assign RX_UNDER_O = rx_under_reg;
  assign RX_FULL_O = rx_full;
  assign TX_EMPTY_O = tx_empty;
  assign CLEAR_ALL_O = clear_all_reg;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  property p_under_set;
    DATA_READ_I && (RX_LEVEL_I == 6'h00) |=> RX_UNDER_O;
  endproperty
  a_under_set: assert property (p_under_set)
    else $error("underflow flag not set on empty read");

  property p_under_dis;
    !INTERNAL_ENABLE_I && !under_event |=> !RX_UNDER_O;
  endproperty
  a_under_dis: assert property (p_under_dis)
    else $error("underflow flag survived internal disable");

  property p_under_hold;
    INTERNAL_ENABLE_I && !under_event && !clear_all_rd |=> $stable(RX_UNDER_O);
  endproperty
  a_under_hold: assert property (p_under_hold)
    else $error("underflow flag changed without cause");

  property p_rx_full_set;
    ENABLE_I && (RX_LEVEL_I > {1'b0, rx_thr}) |=> RX_FULL_O;
  endproperty
  a_rx_full_set: assert property (p_rx_full_set)
    else $error("receive full missing at threshold");

  property p_rx_full_off;
    !ENABLE_I || (RX_LEVEL_I <= {1'b0, rx_thr}) |=> !RX_FULL_O;
  endproperty
  a_rx_full_off: assert property (p_rx_full_off)
    else $error("receive full not cleared");

  property p_tx_empty_set;
    TX_LEVEL_I <= {1'b0, tx_thr} |=> TX_EMPTY_O;
  endproperty
  a_tx_empty_set: assert property (p_tx_empty_set)
    else $error("transmit empty missing at threshold");

  property p_tx_empty_off;
    TX_LEVEL_I > {1'b0, tx_thr} |=> !TX_EMPTY_O;
  endproperty
  a_tx_empty_off: assert property (p_tx_empty_off)
    else $error("transmit empty not cleared");

  property p_rx_thr_write;
    access && PWRITE_I && hit_rx && (PWDATA_I[ift_pkg::THR_W-1:0] <= THR_MAX)
      |=> rx_thr == $past(PWDATA_I[ift_pkg::THR_W-1:0]);
  endproperty
  a_rx_thr_write: assert property (p_rx_thr_write)
    else $error("receive threshold write lost");

  property p_clear_all;
    clear_all_rd && !under_event |=> CLEAR_ALL_O && !RX_UNDER_O ##1 !CLEAR_ALL_O;
  endproperty
  a_clear_all: assert property (p_clear_all)
    else $error("clear-all read did not clear");

  property p_clear_keeps;
    clear_all_rd && ENABLE_I && $stable(RX_LEVEL_I) && RX_FULL_O |=> RX_FULL_O;
  endproperty
  a_clear_keeps: assert property (p_clear_keeps)
    else $error("clear-all touched receive full");

  property p_reserved_zero;
    setup && !PWRITE_I && (hit_rx || hit_tx || hit_clr) |=> PRDATA_O[15:5] == 11'h000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read nonzero");

  c_underflow: cover property (under_event ##[1:20] clear_all_rd);
  c_rx_full: cover property (!RX_FULL_O ##1 RX_FULL_O ##[1:20] !RX_FULL_O);
  c_tx_empty: cover property (TX_EMPTY_O ##1 !TX_EMPTY_O);

endmodule // ift_fifo_thr_irq

// ==== sim/ift_far_model.sv ====
`timescale 1ns/100ps

module ift_far_model (
  input wire logic clk_i,
  output logic data_read_o,
  output logic [ift_pkg::LEVEL_W-1:0] rx_level_o,
  output logic [ift_pkg::LEVEL_W-1:0] tx_level_o,
  output logic enable_o,
  output logic internal_enable_o
);
  initial begin
    data_read_o = 1'b0;
    rx_level_o = 6'h00;
    tx_level_o = 6'h00;
    enable_o = 1'b1;
    internal_enable_o = 1'b1;
  end

  task automatic set_rx(input logic [ift_pkg::LEVEL_W-1:0] l);
    @(posedge clk_i);
    rx_level_o <= l;
  endtask

  task automatic set_tx(input logic [ift_pkg::LEVEL_W-1:0] l);
    @(posedge clk_i);
    tx_level_o <= l;
  endtask

  task automatic data_read();
    @(posedge clk_i);
    data_read_o <= 1'b1;
    @(posedge clk_i);
    data_read_o <= 1'b0;
  endtask

  // Internal enable lags: state machines finish the current transfer first
  task automatic shut(input int idle);
    @(posedge clk_i);
    enable_o <= 1'b0;
    repeat (idle) @(posedge clk_i);
    internal_enable_o <= 1'b0;
  endtask

  task automatic wake();
    @(posedge clk_i);
    enable_o <= 1'b1;
    internal_enable_o <= 1'b1;
  endtask
endmodule // ift_far_model

// ==== sim/ift_fifo_thr_irq_tb.sv ====
`timescale 1ns/100ps

module ift_fifo_thr_irq_tb;
  localparam int DEPTH = 16;
  localparam logic [15:0] OTHER = 16'hffff;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, under, full, empty, clr, e;
  logic [31:0] paddr;
  logic [15:0] pwdata, prdata, q;
  logic drd, en, ien;
  logic [5:0] rxl, txl;
  int err_count = 0;
  int checks = 0;

  ift_fifo_thr_irq #(.FIFO_DEPTH(DEPTH)) ift_fifo_thr_irq_i (.CORE_CLK_I(clk), .RST_I(rst),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .DATA_READ_I(drd),
    .RX_LEVEL_I(rxl), .TX_LEVEL_I(txl), .ENABLE_I(en), .INTERNAL_ENABLE_I(ien),
    .RAW_OTHER_I(OTHER), .RX_UNDER_O(under), .RX_FULL_O(full), .TX_EMPTY_O(empty),
    .CLEAR_ALL_O(clr));

  ift_far_model ift_far_model_i (.clk_i(clk), .data_read_o(drd), .rx_level_o(rxl),
    .tx_level_o(txl), .enable_o(en), .internal_enable_o(ien));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk16(input logic [15:0] g, input logic [15:0] x, input string m);
    checks++;
    if (g !== x) begin
      err_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, g, x);
    end
  endtask

  task automatic chk1(input logic g, input logic x, input string m);
    checks++;
    if (g !== x) begin
      err_count++;
      $display("unexpected at %0t: %s got %b exp %b", $time, m, g, x);
    end
  endtask

  // Access phase held until ready is sampled high, bounded
  task automatic bus(input logic w, input logic [31:0] a, input logic [15:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 8) begin
      n++;
      @(posedge clk);
    end
    if (n == 8) begin
      err_count++;
      $display("unexpected at %0t: bus hang", $time);
      conclude();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [15:0] x, input logic xe);
    bus(1'b0, a, 16'h0000);
    chk16(q, x, "read data");
    chk1(e, xe, "bus error");
  endtask

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic rx(input logic [5:0] l, input logic x);
    ift_far_model_i.set_rx(l);
    step();
    chk1(full, x, "receive full");
  endtask

  task automatic tx(input logic [5:0] l, input logic x);
    ift_far_model_i.set_tx(l);
    step();
    chk1(empty, x, "transmit empty");
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 16'h0000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(ift_pkg::RECEIVE_THRESHOLD_ADDR, 16'h0000, 1'b0);
    rd(ift_pkg::TRANSMIT_THRESHOLD_ADDR, 16'h0000, 1'b0);
    rd(ift_pkg::CLEAR_ALL_INTERRUPTS_ADDR, 16'h0000, 1'b0);
    chk1(empty, 1'b1, "empty at reset");
    $display("test reset done");
    bus(1'b1, ift_pkg::RECEIVE_THRESHOLD_ADDR, 16'hffe3);
    rd(ift_pkg::RECEIVE_THRESHOLD_ADDR, 16'h0003, 1'b0);
    rx(6'h03, 1'b0);
    rx(6'h04, 1'b1);
    rx(6'h03, 1'b0);
    bus(1'b1, ift_pkg::RECEIVE_THRESHOLD_ADDR, 16'h0000);
    rx(6'h01, 1'b1);
    rx(6'h00, 1'b0);
    bus(1'b1, ift_pkg::RECEIVE_THRESHOLD_ADDR, 16'h001f);
    rd(ift_pkg::RECEIVE_THRESHOLD_ADDR, 16'(DEPTH - 1), 1'b0);
    rx(6'(DEPTH), 1'b1);
    rx(6'(DEPTH - 1), 1'b0);
    $display("test receive threshold done");
    bus(1'b1, ift_pkg::TRANSMIT_THRESHOLD_ADDR, 16'h0005);
    tx(6'h05, 1'b1);
    tx(6'h06, 1'b0);
    bus(1'b1, ift_pkg::TRANSMIT_THRESHOLD_ADDR, 16'hffff);
    rd(ift_pkg::TRANSMIT_THRESHOLD_ADDR, 16'(DEPTH - 1), 1'b0);
    tx(6'(DEPTH - 1), 1'b1);
    tx(6'(DEPTH), 1'b0);
    bus(1'b1, ift_pkg::TRANSMIT_THRESHOLD_ADDR, 16'h0005);
    tx(6'h00, 1'b1);
    $display("test transmit threshold done");
    rx(6'h02, 1'b0);
    ift_far_model_i.data_read();
    #1;
    chk1(under, 1'b0, "underflow with data");
    rx(6'h00, 1'b0);
    ift_far_model_i.data_read();
    #1;
    chk1(under, 1'b1, "underflow set");
    rd(ift_pkg::RAW_INTERRUPT_STATUS_ADDR, (OTHER & 16'hffea) | 16'h0011, 1'b0);
    rd(ift_pkg::CLEAR_ALL_INTERRUPTS_ADDR, 16'h0000, 1'b0);
    #1;
    chk1(clr, 1'b1, "clear pulse");
    chk1(under, 1'b0, "underflow cleared");
    chk1(empty, 1'b1, "empty kept");
    step();
    chk1(clr, 1'b0, "clear pulse end");
    $display("test clear all done");
    ift_far_model_i.data_read();
    bus(1'b1, ift_pkg::RECEIVE_THRESHOLD_ADDR, 16'h0000);
    rx(6'h01, 1'b1);
    ift_far_model_i.shut(3);
    #1;
    chk1(full, 1'b0, "full on disable");
    chk1(under, 1'b1, "underflow held");
    step();
    chk1(under, 1'b0, "underflow dropped");
    ift_far_model_i.wake();
    rx(6'h01, 1'b1);
    rd(ift_pkg::CLEAR_ALL_INTERRUPTS_ADDR, 16'h0000, 1'b0);
    chk1(full, 1'b1, "full kept");
    $display("test disable done");
    rd(32'h5000_1544, 16'h0000, 1'b1);
    bus(1'b1, ift_pkg::CLEAR_ALL_INTERRUPTS_ADDR, 16'hffff);
    rd(ift_pkg::CLEAR_ALL_INTERRUPTS_ADDR, 16'h0000, 1'b0);
    $display("test unmapped done");
    conclude();
  end
endmodule // ift_fifo_thr_irq_tb
